// ---- pcm_cmd_decode.sv ----
// Case-folding decoder for packed ASCII command words
module pcm_cmd_decode
(
	// Packed command word
	input wire logic [31:0] i_word,
	// Decoded command
	output pcm_pkg::pcm_cmd_e o_cmd
);
	import pcm_pkg::*;

	function automatic logic [7:0] fold(input logic [7:0] c);
		fold = (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
	endfunction : fold

	logic [31:0] upper;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_fold
			assign upper[g*8 +: 8] = fold(i_word[g*8 +: 8]);
		end
	endgenerate

	assign o_cmd = (upper == W_CORR) ? PCM_CORR :
		(upper == W_LIN_EN) ? PCM_LIN_EN :
		(upper == W_MPC) ? PCM_MPC :
		(upper == W_LCI) ? PCM_LCI :
		(upper == W_MP_ENTRY) ? PCM_MP_ENTRY :
		(upper == W_DATE_SET) ? PCM_DATE_SET :
		(upper == W_ANA_ENTRY) ? PCM_ANA_ENTRY : PCM_NONE;
endmodule : pcm_cmd_decode

// ---- pcm_host.sv ----
// Host terminal model: Avalon-MM master sending command words
module pcm_host
(
	// Clock
	input wire logic i_clk,
	// Avalon-MM master
	output logic [7:0] o_address,
	output logic o_read,
	output logic o_write,
	output logic [31:0] o_writedata,
	input wire logic [31:0] i_readdata,
	input wire logic i_waitrequest
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		o_address = 8'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0000_0000;
	end
	// One access; entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		o_address <= a;
		o_writedata <= d;
		o_write <= w;
		o_read <= !w;
		@(posedge i_clk);
		while (i_waitrequest)
			@(posedge i_clk);
		q = i_readdata;
		o_read <= 1'b0;
		o_write <= 1'b0;
		o_address <= ~a;
		o_writedata <= ~d;
		repeat (2) @(posedge i_clk);
	endtask : xfer
endmodule : pcm_host

// ---- pcm_manager.sv ----
// Pressure correction manager: command interpreter with Avalon-MM slave
module pcm_manager
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Avalon-MM slave
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// Pins
	input wire logic i_write_protect_switch,
	input wire logic i_key_fast,
	input wire logic i_key_track,
	input wire logic i_key_backlight,
	input wire logic [1:0] i_transducers_fitted,
	// Measurement and display settings
	output logic [7:0] o_integration_time,
	output logic o_smoothing_stage,
	output logic o_serial_track,
	output logic o_display_track,
	output logic [3:0] o_display_layout,
	output logic o_backlight,
	// Correction selection for the measurement path
	output logic o_linear_adjust_enable,
	output logic o_multipoint_adjust_enable,
	output logic o_factory_only
);
	import pcm_pkg::*;

	// Pin synchronisers
	localparam int PIN_N = 4;
	logic [PIN_N-1:0] pin_in;
	logic [PIN_N-1:0] s1_r;
	logic [PIN_N-1:0] s2_r;
	logic [PIN_N-1:0] s3_r;
	logic [PIN_N-1:0] pin_r;
	logic [PIN_N-1:0] pin_prev_r;
	logic [PIN_N-1:0] pin_rise;

	assign pin_in = {i_key_backlight, i_key_track, i_key_fast, i_write_protect_switch};

	genvar g;
	generate
		for (g = 0; g < PIN_N; g++)
		begin : g_sync
			always_ff @(posedge i_clk or negedge i_rst_n)
			begin
				if (!i_rst_n)
				begin
					s1_r[g] <= 1'b0;
					s2_r[g] <= 1'b0;
					s3_r[g] <= 1'b0;
					pin_r[g] <= 1'b0;
					pin_prev_r[g] <= 1'b0;
				end
				else
				begin
					s1_r[g] <= pin_in[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (s2_r[g] == s3_r[g])
						pin_r[g] <= s3_r[g];
					pin_prev_r[g] <= pin_r[g];
				end
			end
			assign pin_rise[g] = pin_r[g] & ~pin_prev_r[g];
		end
	endgenerate

	logic wp_on;
	logic key_fast;
	logic key_track;
	logic key_light;

	assign wp_on = pin_r[0];
	assign key_fast = pin_rise[1];
	assign key_track = pin_rise[2];
	assign key_light = pin_rise[3];

	// Fitted transducer count, caught after reset release
	logic [1:0] fitted_r;
	logic fitted_done_r;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			fitted_r <= 2'h1;
			fitted_done_r <= 1'b0;
		end
		else if (!fitted_done_r)
		begin
			fitted_r <= (i_transducers_fitted == 2'h0) ? 2'h1 : i_transducers_fitted;
			fitted_done_r <= 1'b1;
		end
	end

	// Bus handshake: one wait cycle then the answer
	logic req;
	logic take;
	logic do_wr;
	logic do_rd;
	logic wait_r;
	logic [31:0] rdata_r;

	assign req = i_read | i_write;
	assign take = req & wait_r;
	assign do_wr = i_write & ~wait_r;
	assign do_rd = i_read & wait_r;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// Command decode
	pcm_cmd_e cmd;
	logic cmd_wr;
	logic arg_on;
	logic [1:0] arg_x;
	logic [31:0] arg_r;

	pcm_cmd_decode u_dec
	(
		.i_word(i_writedata),
		.o_cmd(cmd)
	);

	assign cmd_wr = do_wr & hit(i_address, ADR_CMD);
	assign arg_on = arg_r[ARG_ON_BIT];
	assign arg_x = arg_r[ARG_XDCR_LSB +: 2];

	// Correction state
	logic lin_en_r;
	logic mp_en_r;
	logic date_ok_r;
	logic [31:0] date_r;
	logic refused_r;
	logic bad_order_r;
	logic entry_r;
	logic entry_mp_r;
	logic [1:0] entry_x_r;
	logic [3:0] cnt_r [2][XDCR_N];
	logic [15:0] last_rd_r;
	logic [31:0] rsel_r;

	logic x_ok;
	logic guard_ok;
	logic is_enable_cmd;
	logic is_entry_cmd;
	logic cmd_refused;
	logic cmd_accept;
	logic entry_wr;
	logic [3:0] entry_cnt;
	logic [3:0] entry_lim;
	logic entry_full;
	logic entry_store;
	logic entry_desc;

	assign x_ok = (arg_x != 2'h0) && (arg_x <= fitted_r);
	assign is_enable_cmd = (cmd == PCM_LIN_EN) || (cmd == PCM_MPC);
	assign is_entry_cmd = (cmd == PCM_LCI) || (cmd == PCM_MP_ENTRY) || (cmd == PCM_ANA_ENTRY);
	assign guard_ok = wp_on;
	assign cmd_refused = cmd_wr && (((is_enable_cmd || is_entry_cmd) && !guard_ok) ||
		(is_entry_cmd && !x_ok) || (cmd == PCM_NONE));
	assign cmd_accept = cmd_wr && !cmd_refused;

	assign entry_wr = do_wr & hit(i_address, ADR_ENTRY) & entry_r;
	assign entry_cnt = cnt_r[entry_mp_r][entry_x_r - 2'h1];
	assign entry_lim = entry_mp_r ? LEVEL_MAX : LIN_LEVEL_MAX;
	assign entry_full = entry_cnt >= entry_lim;
	assign entry_desc = (entry_cnt != 4'h0) && (i_writedata[15:0] <= last_rd_r);
	assign entry_store = entry_wr && guard_ok && !entry_full && !entry_desc;

	// Table storage
	logic [31:0] tbl_rdata;
	logic rs_mp;
	logic [1:0] rs_x;
	logic [2:0] rs_l;

	assign rs_mp = rsel_r[RS_MP_BIT];
	assign rs_x = rsel_r[RS_XDCR_LSB +: 2];
	assign rs_l = rsel_r[RS_LEVEL_LSB +: 3];

	pcm_table u_tbl
	(
		.i_clk(i_clk),
		.i_we(entry_store),
		.i_wmp(entry_mp_r),
		.i_wx(entry_x_r),
		.i_wl(entry_cnt[2:0]),
		.i_wdata(i_writedata),
		.i_rmp(rs_mp),
		.i_rx(rs_x),
		.i_rl(rs_l),
		.o_rdata(tbl_rdata)
	);

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			lin_en_r <= 1'b0;
			mp_en_r <= 1'b0;
			date_ok_r <= 1'b0;
			refused_r <= 1'b0;
			entry_r <= 1'b0;
			entry_mp_r <= 1'b0;
			entry_x_r <= 2'h1;
			bad_order_r <= 1'b0;
			last_rd_r <= 16'h0000;
			for (int k = 0; k < 2; k++)
				for (int x = 0; x < XDCR_N; x++)
					cnt_r[k][x] <= 4'h0;
		end
		else
		begin
			if (cmd_wr)
			begin
				refused_r <= cmd_refused;
				bad_order_r <= 1'b0;
				entry_r <= 1'b0;
			end
			if (cmd_accept && is_enable_cmd)
			begin
				if (cmd == PCM_LIN_EN)
					lin_en_r <= arg_on;
				else
					mp_en_r <= arg_on;
				date_ok_r <= 1'b0;
			end
			if (cmd_accept && is_entry_cmd)
			begin
				entry_r <= 1'b1;
				entry_mp_r <= (cmd == PCM_MP_ENTRY);
				entry_x_r <= arg_x;
				cnt_r[cmd == PCM_MP_ENTRY][arg_x - 2'h1] <= 4'h0;
				if (cmd == PCM_MP_ENTRY)
					mp_en_r <= 1'b0;
				else
					lin_en_r <= 1'b0;
				date_ok_r <= 1'b0;
			end
			if (cmd_accept && cmd == PCM_DATE_SET)
				date_ok_r <= 1'b1;
			if (entry_wr)
			begin
				refused_r <= !entry_store;
				bad_order_r <= entry_desc;
			end
			if (entry_store)
			begin
				cnt_r[entry_mp_r][entry_x_r - 2'h1] <= entry_cnt + 4'h1;
				last_rd_r <= i_writedata[15:0];
				date_ok_r <= 1'b0;
			end
		end
	end

	// Plain registers: argument, date, report select
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			arg_r <= 32'h0000_0000;
			date_r <= 32'h0000_0000;
			rsel_r <= 32'h0000_0000;
		end
		else
		begin
			if (do_wr && hit(i_address, ADR_ARG))
				arg_r <= i_writedata;
			if (do_wr && hit(i_address, ADR_CALDATE))
				date_r <= i_writedata;
			if (do_wr && hit(i_address, ADR_RSEL))
				rsel_r <= i_writedata;
		end
	end

	// Report view: disabled kinds and levels beyond the stored rows read as zero
	logic rs_en;
	logic rs_valid;
	logic [3:0] rs_cnt;
	logic [31:0] report_word;

	assign rs_en = rs_mp ? mp_en_r : lin_en_r;
	assign rs_cnt = (rs_x == 2'h0 || rs_x > fitted_r) ? 4'h0 : cnt_r[rs_mp][rs_x - 2'h1];
	assign rs_valid = rs_en && ({1'b0, rs_l} < rs_cnt);
	assign report_word = rs_valid ? tbl_rdata : 32'h0000_0000;

	// Keyboard-side settings
	logic [7:0] itime_r;
	logic smooth_r;
	logic ser_trk_r;
	logic disp_trk_r;
	logic [3:0] layout_r;
	logic light_r;
	logic setup_wr;

	assign setup_wr = do_wr & hit(i_address, ADR_SETUP);

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			itime_r <= ITIME_RST;
			smooth_r <= 1'b1;
			ser_trk_r <= 1'b0;
			disp_trk_r <= 1'b0;
			layout_r <= LAYOUT_RST;
			light_r <= 1'b0;
		end
		else
		begin
			if (setup_wr)
			begin
				itime_r <= i_writedata[SU_ITIME_LSB +: 8];
				smooth_r <= i_writedata[SU_SMOOTH];
				ser_trk_r <= i_writedata[SU_SERTRK];
				layout_r <= i_writedata[SU_LAYOUT_LSB +: 4];
			end
			if (key_fast)
			begin
				itime_r <= ITIME_FAST;
				smooth_r <= 1'b0;
			end
			if (key_track)
				disp_trk_r <= ~disp_trk_r;
			if (key_light)
				light_r <= ~light_r;
		end
	end

	// Read mux
	logic [15:0] st_lo;
	logic [31:0] rd_mux;

	assign st_lo = {!lin_en_r && !mp_en_r, (cnt_r[0][entry_x_r - 2'h1] == LIN_LEVEL_MAX),
		fitted_r, entry_cnt, bad_order_r, entry_mp_r, entry_r, refused_r, wp_on,
		date_ok_r, mp_en_r, lin_en_r};
	assign rd_mux = hit(i_address, ADR_STATUS) ? {16'h0000, st_lo} :
		hit(i_address, ADR_ARG) ? arg_r :
		hit(i_address, ADR_CALDATE) ? (date_ok_r ? date_r : 32'h0000_0000) :
		hit(i_address, ADR_RSEL) ? rsel_r :
		hit(i_address, ADR_RDATA) ? report_word :
		hit(i_address, ADR_SETUP) ? {16'h0000, layout_r, 2'h0, ser_trk_r, smooth_r, itime_r} :
		hit(i_address, ADR_FACTORY) ? FACTORY_COEF : 32'h0000_0000;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end
		else
		begin
			wait_r <= !take;
			if (do_rd)
				rdata_r <= rd_mux;
		end
	end

	// Output flops
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_integration_time <= ITIME_RST;
			o_smoothing_stage <= 1'b1;
			o_serial_track <= 1'b0;
			o_display_track <= 1'b0;
			o_display_layout <= LAYOUT_RST;
			o_backlight <= 1'b0;
			o_linear_adjust_enable <= 1'b0;
			o_multipoint_adjust_enable <= 1'b0;
			o_factory_only <= 1'b1;
		end
		else
		begin
			o_integration_time <= itime_r;
			o_smoothing_stage <= smooth_r;
			o_serial_track <= ser_trk_r;
			o_display_track <= disp_trk_r;
			o_display_layout <= disp_trk_r ? LAYOUT_MINMAX : layout_r;
			o_backlight <= light_r;
			o_linear_adjust_enable <= lin_en_r;
			o_multipoint_adjust_enable <= mp_en_r;
			o_factory_only <= !lin_en_r && !mp_en_r;
		end
	end

	assign o_readdata = rdata_r;
	assign o_waitrequest = wait_r;
endmodule : pcm_manager

// ---- pcm_manager_assertions.sv ----
// Port checker for the correction manager
module pcm_chk import pcm_pkg::*;
(
	// Clock, reset, bus
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	// Keys and settings
	input wire logic i_key_fast,
	input wire logic i_key_backlight,
	input wire logic [7:0] o_integration_time,
	input wire logic o_smoothing_stage,
	input wire logic o_serial_track,
	input wire logic o_display_track,
	input wire logic [3:0] o_display_layout,
	input wire logic o_backlight,
	// Correction flags
	input wire logic o_linear_adjust_enable,
	input wire logic o_multipoint_adjust_enable,
	input wire logic o_factory_only
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	a_wait_one_cycle: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("waitrequest low too long");
	a_wait_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("no answer one cycle after request");
	a_factory_word: assert property (
		i_read && i_address == ADR_FACTORY && !o_waitrequest |-> o_readdata == FACTORY_COEF)
		else $error("factory word wrong");
	a_fast_key_itime: assert property ($rose(i_key_fast) |-> ##[1:8]
		(o_integration_time == ITIME_FAST && !o_smoothing_stage))
		else $error("fast key settings missing");
	a_track_layout: assert property (
		o_display_track && $past(o_display_track) |-> o_display_layout == LAYOUT_MINMAX)
		else $error("tracking layout wrong");
	a_disp_keeps_ser: assert property (
		$changed(o_display_track) |-> $stable(o_serial_track))
		else $error("serial tracking disturbed");
	a_ser_keeps_disp: assert property (
		$changed(o_serial_track) |-> $stable(o_display_track))
		else $error("display tracking disturbed");
	a_backlight_key: assert property (
		(!i_key_backlight) [*8] |=> $stable(o_backlight))
		else $error("backlight moved without key");
	a_factory_only: assert property (
		o_factory_only == !(o_linear_adjust_enable || o_multipoint_adjust_enable))
		else $error("factory only flag wrong");
	c_both_on: cover property (o_linear_adjust_enable && o_multipoint_adjust_enable);
	c_fast: cover property ($rose(i_key_fast));
	c_track: cover property (o_display_track);
endmodule : pcm_chk
bind pcm_manager pcm_chk chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address),
	.i_read(i_read), .i_write(i_write), .o_readdata(o_readdata),
	.o_waitrequest(o_waitrequest), .i_key_fast(i_key_fast), .i_key_backlight(i_key_backlight),
	.o_integration_time(o_integration_time), .o_smoothing_stage(o_smoothing_stage),
	.o_serial_track(o_serial_track), .o_display_track(o_display_track),
	.o_display_layout(o_display_layout), .o_backlight(o_backlight),
	.o_linear_adjust_enable(o_linear_adjust_enable),
	.o_multipoint_adjust_enable(o_multipoint_adjust_enable), .o_factory_only(o_factory_only));

// ---- pcm_pkg.sv ----
// Shared constants and types for the pressure correction manager
package pcm_pkg;
	// Avalon-MM word offsets (byte addresses)
	localparam logic [7:0] ADR_CMD = 8'h00;
	localparam logic [7:0] ADR_ARG = 8'h04;
	localparam logic [7:0] ADR_ENTRY = 8'h08;
	localparam logic [7:0] ADR_STATUS = 8'h0C;
	localparam logic [7:0] ADR_CALDATE = 8'h10;
	localparam logic [7:0] ADR_RSEL = 8'h14;
	localparam logic [7:0] ADR_RDATA = 8'h18;
	localparam logic [7:0] ADR_SETUP = 8'h1C;
	localparam logic [7:0] ADR_FACTORY = 8'h20;
	// Argument fields
	localparam int ARG_XDCR_LSB = 0;
	localparam int ARG_ON_BIT = 8;
	// Status fields
	localparam int ST_LIN = 0;
	localparam int ST_MP = 1;
	localparam int ST_DATE_OK = 2;
	localparam int ST_WP = 3;
	localparam int ST_REFUSED = 4;
	localparam int ST_ENTRY = 5;
	localparam int ST_KIND_MP = 6;
	localparam int ST_BADORDER = 7;
	localparam int ST_COUNT_LSB = 8;
	localparam int ST_XDCRS_LSB = 12;
	localparam int ST_GAIN = 14;
	localparam int ST_FACT_ONLY = 15;
	// Report select fields
	localparam int RS_LEVEL_LSB = 0;
	localparam int RS_XDCR_LSB = 4;
	localparam int RS_MP_BIT = 8;
	// Setup register fields
	localparam int SU_ITIME_LSB = 0;
	localparam int SU_SMOOTH = 8;
	localparam int SU_SERTRK = 9;
	localparam int SU_LAYOUT_LSB = 12;
	// Table geometry
	localparam int XDCR_N = 3;
	localparam int LEVEL_N = 8;
	localparam int LIN_LEVEL_N = 2;
	localparam logic [3:0] LEVEL_MAX = 4'h8;
	localparam logic [3:0] LIN_LEVEL_MAX = 4'h2;
	// Reset and forced values
	localparam logic [7:0] ITIME_FAST = 8'h20;
	localparam logic [7:0] ITIME_RST = 8'h10;
	localparam logic [3:0] LAYOUT_RST = 4'h0;
	localparam logic [3:0] LAYOUT_MINMAX = 4'hF;
	// Factory coefficient word, arbitrary value
	localparam logic [31:0] FACTORY_COEF = 32'h0000_1000;
	// Command words and decoded command kinds
	typedef enum logic [2:0] {PCM_NONE, PCM_CORR, PCM_LIN_EN, PCM_MPC, PCM_LCI, PCM_MP_ENTRY,
		PCM_DATE_SET, PCM_ANA_ENTRY} pcm_cmd_e;
	localparam logic [31:0] W_CORR = 32'h434F_5252;
	localparam logic [31:0] W_LIN_EN = 32'h0000_4C43;
	localparam logic [31:0] W_MPC = 32'h004D_5043;
	localparam logic [31:0] W_LCI = 32'h004C_4349;
	localparam logic [31:0] W_MP_ENTRY = 32'h4D50_4349;
	localparam logic [31:0] W_DATE_SET = 32'h4341_4C44;
	localparam logic [31:0] W_ANA_ENTRY = 32'h444C_4349;
endpackage : pcm_pkg

// ---- pcm_table.sv ----
// Correction table storage, one row of levels per transducer and kind
module pcm_table
(
	// Clock
	input wire logic i_clk,
	// Write port
	input wire logic i_we,
	input wire logic i_wmp,
	input wire logic [1:0] i_wx,
	input wire logic [2:0] i_wl,
	input wire logic [31:0] i_wdata,
	// Read port
	input wire logic i_rmp,
	input wire logic [1:0] i_rx,
	input wire logic [2:0] i_rl,
	output logic [31:0] o_rdata
);
	import pcm_pkg::*;

	logic [31:0] mem_r [2*(XDCR_N+1)*LEVEL_N];
	logic [5:0] wa;
	logic [5:0] ra;

	assign wa = {i_wmp, i_wx, i_wl};
	assign ra = {i_rmp, i_rx, i_rl};
	assign o_rdata = mem_r[ra];

	always_ff @(posedge i_clk)
	begin
		if (i_we)
			mem_r[wa] <= i_wdata;
	end
endmodule : pcm_table

// ---- tb_top.sv ----
// Self-checking bench for the correction manager
`define CHK(g, e) \
	begin \
		check_count++; \
		if ((g) !== (e)) \
		begin \
			fails++; \
			$display("wrong value at %0t: %h expected %h", $time, (g), (e)); \
		end \
	end
module tb_top import pcm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk, rst_n, wp, rd_s, wr_s, wreq, smooth, strk, dtrk, blight, lin, mp, fonly;
	logic [2:0] keys;
	logic [7:0] adr, itime;
	logic [31:0] wd, rdat, rdv;
	logic [3:0] layout;
	int fails = 0;
	int check_count = 0;
	pcm_manager uut (.i_clk(i_clk), .i_rst_n(rst_n), .i_address(adr), .i_read(rd_s),
		.i_write(wr_s), .i_writedata(wd), .o_readdata(rdat), .o_waitrequest(wreq),
		.i_write_protect_switch(wp), .i_key_fast(keys[0]), .i_key_track(keys[1]),
		.i_key_backlight(keys[2]), .i_transducers_fitted(2'h3), .o_integration_time(itime),
		.o_smoothing_stage(smooth), .o_serial_track(strk), .o_display_track(dtrk),
		.o_display_layout(layout), .o_backlight(blight), .o_linear_adjust_enable(lin),
		.o_multipoint_adjust_enable(mp), .o_factory_only(fonly));
	pcm_host host (.i_clk(i_clk), .o_address(adr), .o_read(rd_s), .o_write(wr_s),
		.o_writedata(wd), .i_readdata(rdat), .i_waitrequest(wreq));
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rdv);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0000_0000, rdv);
	endtask : rd
	task automatic cmd(input logic [31:0] w, input logic [31:0] arg);
		wr(ADR_ARG, arg);
		wr(ADR_CMD, w);
		rd(ADR_STATUS);
	endtask : cmd
	task automatic rsel(input logic [31:0] s);
		wr(ADR_RSEL, s);
		rd(ADR_RDATA);
	endtask : rsel
	task automatic press(input int k);
		keys[k] <= 1'b1;
		repeat (4) @(posedge i_clk);
		keys[k] <= 1'b0;
		repeat (8) @(posedge i_clk);
	endtask : press
	task automatic t_reset();
		`CHK(itime, ITIME_RST)
		`CHK(smooth, 1'b1)
		`CHK(fonly, 1'b1)
		rd(ADR_FACTORY);
		`CHK(rdv, FACTORY_COEF)
		rd(8'h40);
		`CHK(rdv, 32'h0000_0000)
		$display("t_reset done");
	endtask : t_reset
	task automatic t_protect();
		cmd(W_LIN_EN, 32'h0000_0101);
		`CHK(rdv[4], 1'b1)
		`CHK(rdv[3], 1'b0)
		`CHK(lin, 1'b0)
		cmd(W_CORR, 32'h0000_0000);
		`CHK(rdv[4], 1'b0)
		$display("t_protect done");
	endtask : t_protect
	task automatic t_linear();
		wp <= 1'b1;
		repeat (6) @(posedge i_clk);
		wr(ADR_CALDATE, 32'h0000_0A0B);
		cmd(W_DATE_SET | 32'h2020_2020, 32'h0000_0000);
		`CHK(rdv[2], 1'b1)
		rd(ADR_CALDATE);
		`CHK(rdv, 32'h0000_0A0B)
		`CHK(rdv[3], 1'b1)
		cmd(W_LCI | 32'h0020_0000, 32'h0000_0001);
		wr(ADR_ENTRY, 32'h0001_0100);
		wr(ADR_ENTRY, 32'h0002_0200);
		rd(ADR_STATUS);
		`CHK(rdv[14], 1'b1)
		`CHK(rdv[2], 1'b0)
		`CHK(lin, 1'b0)
		wr(ADR_ENTRY, 32'h0003_0300);
		rd(ADR_STATUS);
		`CHK(rdv[4], 1'b1)
		cmd(W_LIN_EN, 32'h0000_0101);
		`CHK(lin, 1'b1)
		`CHK(fonly, 1'b0)
		rsel(32'h0000_0011);
		`CHK(rdv, 32'h0002_0200)
		cmd(W_LCI, 32'h0000_0001);
		`CHK(lin, 1'b0)
		wr(ADR_ENTRY, 32'h0004_0400);
		cmd(W_LIN_EN, 32'h0000_0101);
		rsel(32'h0000_0011);
		`CHK(rdv, 32'h0000_0000)
		rsel(32'h0000_0010);
		`CHK(rdv, 32'h0004_0400)
		cmd(W_LCI, 32'h0000_0000);
		`CHK(rdv[4], 1'b1)
		$display("t_linear done");
	endtask : t_linear
	task automatic t_multi();
		cmd(W_MP_ENTRY | 32'h2000_2000, 32'h0000_0002);
		wr(ADR_ENTRY, 32'h0000_0100);
		wr(ADR_ENTRY, 32'h0000_0050);
		rd(ADR_STATUS);
		`CHK(rdv[7], 1'b1)
		for (int i = 1; i < 8; i++)
			wr(ADR_ENTRY, {16'(i), 16'h0100 + 16'(i) * 16'h0010});
		rd(ADR_STATUS);
		`CHK(rdv[11:8], LEVEL_MAX)
		wr(ADR_ENTRY, 32'h0000_0F00);
		rd(ADR_STATUS);
		`CHK(rdv[4], 1'b1)
		cmd(W_MPC, 32'h0000_0101);
		`CHK(mp, 1'b1)
		rsel(32'h0000_0127);
		`CHK(rdv, 32'h0007_0170)
		rsel(32'h0000_0130);
		`CHK(rdv, 32'h0000_0000)
		cmd(W_MPC, 32'h0000_0000);
		cmd(W_LIN_EN, 32'h0000_0000);
		`CHK(fonly, 1'b1)
		cmd(W_ANA_ENTRY | 32'h2020_2020, 32'h0000_0003);
		`CHK(rdv[5], 1'b1)
		`CHK(rdv[6], 1'b0)
		$display("t_multi done");
	endtask : t_multi
	task automatic t_keys();
		logic b;
		wr(ADR_SETUP, 32'h0000_3310);
		`CHK(strk, 1'b1)
		`CHK(layout, 4'h3)
		press(0);
		`CHK(itime, ITIME_FAST)
		`CHK(smooth, 1'b0)
		press(1);
		`CHK(dtrk, 1'b1)
		`CHK(layout, LAYOUT_MINMAX)
		`CHK(strk, 1'b1)
		wr(ADR_SETUP, 32'h0000_0010);
		`CHK(dtrk, 1'b1)
		b = blight;
		press(2);
		`CHK(blight, !b)
		$display("t_keys done");
	endtask : t_keys
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	initial
	begin
		i_clk = 1'b0;
		forever
			#50 i_clk = ~i_clk;
	end
	initial
	begin
		rst_n = 1'b0;
		wp = 1'b0;
		keys = 3'h0;
		repeat (8) @(posedge i_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		t_reset();
		t_protect();
		t_linear();
		t_multi();
		t_keys();
		complete_run();
	end
	initial
	begin
		repeat (20000) @(posedge i_clk);
		fails++;
		complete_run();
	end
endmodule : tb_top
